// [fcev_pkg.sv]
// package for the flash clock divider and erase verify sequencer
// assumes a 32-bit axi4-lite register bus and a single bus clock
package fcev_pkg;

	// register byte offsets
	localparam logic [4:0] OFF_DIV = 5'h00;
	localparam logic [4:0] OFF_STAT = 5'h04;
	localparam logic [4:0] OFF_CMD = 5'h08;
	localparam logic [4:0] OFF_TEST = 5'h0C;
	localparam logic [4:0] OFF_ARRAY = 5'h10;

	// flash_clock_divider fields
	localparam int unsigned DIV_LOADED_BIT = 7;
	localparam int unsigned DIV_PRESCALE_BIT = 6;
	localparam int unsigned DIV_FIELD_W = 6;
	localparam logic [DIV_FIELD_W-1:0] DIV_FIELD_RESET = 6'h00;

	// flash_status_register fields
	localparam int unsigned STAT_CBE_BIT = 7;
	localparam int unsigned STAT_CC_BIT = 6;
	localparam int unsigned STAT_ACCESS_ERROR_FLAG_BIT = 4;
	localparam int unsigned STAT_BLANK_BIT = 2;

	// flash_command_register
	localparam int unsigned CMD_W = 7;
	localparam logic [CMD_W-1:0] CMD_RESET = 7'h00;
	localparam logic [CMD_W-1:0] CMD_ERASE_VERIFY = 7'h05;

	// flash_test_mode_register
	localparam int unsigned MARGIN_W = 2;
	localparam int unsigned TEST_MARGIN_LSB = 4;
	localparam logic [MARGIN_W-1:0] MARGIN_RESET = 2'h0;

	// last prescaler count when prescale_select is set, divide by eight
	localparam logic [2:0] PRESCALE_LAST = 3'h7;

	// erase verify timing, bus cycles
	localparam int unsigned EV_OVERHEAD = 14;
	localparam int unsigned EV_SCAN_START = 7;

	// axi response codes
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic loaded;
		logic prescale_select;
		logic [DIV_FIELD_W-1:0] divide_field;
	} fcev_div_t;

	typedef struct packed {
		logic cbe;
		logic cc;
		logic access_error_flag;
		logic blank;
	} fcev_stat_t;

	typedef enum logic [1:0] {
		SEQ_IDLE,
		SEQ_ADDR,
		SEQ_CMD
	} fcev_seq_t;

	typedef enum logic {
		ENG_IDLE,
		ENG_VERIFY
	} fcev_eng_t;

endpackage : fcev_pkg

// [fcev_clk_div.sv]
// flash timing clock divider: oscillator strobes down to a timing tick
// assumes osc_tick is a one-cycle strobe synchronous to aclk
module fcev_clk_div (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic osc_tick,
	input fcev_pkg::fcev_div_t div,
	output logic flash_timing_tick
);

	logic [2:0] pre_q;
	logic [2:0] pre_d;
	logic [fcev_pkg::DIV_FIELD_W-1:0] cnt_q;
	logic [fcev_pkg::DIV_FIELD_W-1:0] cnt_d;
	logic tick_q;
	logic tick_d;
	logic pre_tick;

	always_comb begin
		pre_d = pre_q;
		cnt_d = cnt_q;
		tick_d = 1'b0;
		pre_tick = 1'b0;
		// optional divide by eight ahead of the main divider
		if (osc_tick) begin
			if (!div.prescale_select || pre_q == fcev_pkg::PRESCALE_LAST) begin
				pre_d = 3'h0;
				pre_tick = 1'b1;
			end else begin
				pre_d = pre_q + 3'h1;
			end
		end
		// ratio divide_field plus one
		if (pre_tick) begin
			if (cnt_q >= div.divide_field) begin
				cnt_d = '0;
				tick_d = div.loaded;
			end else begin
				cnt_d = cnt_q + 6'h01;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pre_q <= 3'h0;
			cnt_q <= '0;
			tick_q <= 1'b0;
		end else begin
			pre_q <= pre_d;
			cnt_q <= cnt_d;
			tick_q <= tick_d;
		end
	end

	assign flash_timing_tick = tick_q;

endmodule : fcev_clk_div

// [fcev_top.sv]
// flash command sequencer: timing clock divider setup and erase verify
// assumes an axi4-lite master on aclk and a flash array read port
// that answers in the same cycle on array_blank
//
// Operation
// - divider register holds prescale_select and six-bit divide_field
// - any divider write with s_axi_wstrb[0] set sets divider_loaded_flag, clear means not yet written
// - without a divider write, launch is refused and access_error_flag sets
// - sequence opens with an array write, selected blocks taken from it
// - command code 0x05 decodes as erase verify
// - writing one to command_buffer_empty_flag clears it and launches
// - completion sets command_complete_flag unless another command is buffered
// - erase verify lasts block addresses plus 14 bus cycles
// - all selected addresses erased sets the blank flag on completion
// - any non-erased address ends the verify early, blank left clear
// - margin_read_select drives the read margin during erase verify
// - operation timing scales with the flash timing clock period; the erase verify here counts fixed bus cycles and ignores the tick
//
// Implementation choices: the AXI4-Lite slave port and the register offsets.
module fcev_top #(
	parameter int unsigned BLOCK_ADDRS = 32768,
	parameter int unsigned NUM_BLOCKS = 4
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [4:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [4:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic osc_tick,
	output logic flash_timing_tick,
	output logic array_rd_en,
	output logic [$clog2(BLOCK_ADDRS)-1:0] array_rd_addr,
	output logic [NUM_BLOCKS-1:0] array_rd_blocks,
	output logic [fcev_pkg::MARGIN_W-1:0] array_margin,
	input wire logic [NUM_BLOCKS-1:0] array_blank
);

	localparam int unsigned AW = $clog2(BLOCK_ADDRS);
	localparam int unsigned CNT_W = $clog2(BLOCK_ADDRS + fcev_pkg::EV_OVERHEAD + fcev_pkg::EV_SCAN_START);
	localparam logic [CNT_W-1:0] CNT_DONE = CNT_W'(BLOCK_ADDRS + fcev_pkg::EV_OVERHEAD - 2);
	localparam logic [CNT_W-1:0] CNT_SCAN_LO = CNT_W'(fcev_pkg::EV_SCAN_START);
	localparam logic [CNT_W-1:0] CNT_SCAN_HI = CNT_W'(fcev_pkg::EV_SCAN_START + BLOCK_ADDRS);

	// bus slave state
	logic aw_q;
	logic aw_d;
	logic [4:0] awaddr_q;
	logic [4:0] awaddr_d;
	logic w_q;
	logic w_d;
	logic [31:0] wdata_q;
	logic [31:0] wdata_d;
	logic wstrb0_q;
	logic wstrb0_d;
	logic bvalid_q;
	logic bvalid_d;
	logic [1:0] bresp_q;
	logic [1:0] bresp_d;
	logic rvalid_q;
	logic rvalid_d;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic [1:0] rresp_q;
	logic [1:0] rresp_d;
	logic wr_fire;
	logic wr_hit;
	logic [31:0] rd_mux;
	logic rd_hit;

	// register state
	fcev_pkg::fcev_div_t div_q;
	fcev_pkg::fcev_div_t div_d;
	fcev_pkg::fcev_stat_t stat_q;
	fcev_pkg::fcev_stat_t stat_d;
	logic [fcev_pkg::CMD_W-1:0] cmd_q;
	logic [fcev_pkg::CMD_W-1:0] cmd_d;
	logic [fcev_pkg::MARGIN_W-1:0] margin_q;
	logic [fcev_pkg::MARGIN_W-1:0] margin_d;
	fcev_pkg::fcev_seq_t seq_q;
	fcev_pkg::fcev_seq_t seq_d;
	logic [NUM_BLOCKS-1:0] sel_q;
	logic [NUM_BLOCKS-1:0] sel_d;
	logic pend_q;
	logic pend_d;

	// engine state
	fcev_pkg::fcev_eng_t eng_q;
	fcev_pkg::fcev_eng_t eng_d;
	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] cnt_d;
	logic [NUM_BLOCKS-1:0] run_sel_q;
	logic [NUM_BLOCKS-1:0] run_sel_d;
	logic rd_en_q;
	logic rd_en_d;
	logic [AW-1:0] rd_addr_q;
	logic [AW-1:0] rd_addr_d;
	logic start;
	logic eng_done;
	logic eng_fail;
	logic launch;

	// axi4-lite slave, one write and one read in flight
	assign s_axi_awready = !aw_q && !bvalid_q;
	assign s_axi_wready = !w_q && !bvalid_q;
	assign s_axi_arready = !rvalid_q;
	assign wr_fire = aw_q && w_q && !bvalid_q;
	assign wr_hit = awaddr_q[1:0] == 2'h0 && awaddr_q <= fcev_pkg::OFF_ARRAY;

	always_comb begin
		rd_mux = 32'h0000_0000;
		rd_hit = 1'b1;
		case (s_axi_araddr)
			fcev_pkg::OFF_DIV: rd_mux[7:0] = div_q;
			fcev_pkg::OFF_STAT: begin
				rd_mux[fcev_pkg::STAT_CBE_BIT] = stat_q.cbe;
				rd_mux[fcev_pkg::STAT_CC_BIT] = stat_q.cc;
				rd_mux[fcev_pkg::STAT_ACCESS_ERROR_FLAG_BIT] = stat_q.access_error_flag;
				rd_mux[fcev_pkg::STAT_BLANK_BIT] = stat_q.blank;
			end
			fcev_pkg::OFF_CMD: rd_mux[fcev_pkg::CMD_W-1:0] = cmd_q;
			fcev_pkg::OFF_TEST: rd_mux[fcev_pkg::TEST_MARGIN_LSB +: fcev_pkg::MARGIN_W] = margin_q;
			fcev_pkg::OFF_ARRAY: rd_mux = 32'h0000_0000;
			default: rd_hit = 1'b0;
		endcase
	end

	always_comb begin
		aw_d = aw_q;
		awaddr_d = awaddr_q;
		w_d = w_q;
		wdata_d = wdata_q;
		wstrb0_d = wstrb0_q;
		bvalid_d = bvalid_q;
		bresp_d = bresp_q;
		rvalid_d = rvalid_q;
		rdata_d = rdata_q;
		rresp_d = rresp_q;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_d = 1'b1;
			awaddr_d = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_d = 1'b1;
			wdata_d = s_axi_wdata;
			wstrb0_d = s_axi_wstrb[0];
		end
		if (wr_fire) begin
			aw_d = 1'b0;
			w_d = 1'b0;
			bvalid_d = 1'b1;
			bresp_d = wr_hit ? fcev_pkg::RESP_OKAY : fcev_pkg::RESP_SLVERR;
		end else if (bvalid_q && s_axi_bready) begin
			bvalid_d = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			rvalid_d = 1'b1;
			rdata_d = rd_mux;
			rresp_d = rd_hit ? fcev_pkg::RESP_OKAY : fcev_pkg::RESP_SLVERR;
		end else if (rvalid_q && s_axi_rready) begin
			rvalid_d = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_q <= 1'b0;
			awaddr_q <= 5'h00;
			w_q <= 1'b0;
			wdata_q <= 32'h0000_0000;
			wstrb0_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= fcev_pkg::RESP_OKAY;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= fcev_pkg::RESP_OKAY;
		end else begin
			aw_q <= aw_d;
			awaddr_q <= awaddr_d;
			w_q <= w_d;
			wdata_q <= wdata_d;
			wstrb0_q <= wstrb0_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
			rvalid_q <= rvalid_d;
			rdata_q <= rdata_d;
			rresp_q <= rresp_d;
		end
	end

	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;

	// register file and command write sequence
	assign launch = wr_fire && wstrb0_q && awaddr_q == fcev_pkg::OFF_STAT && wdata_q[fcev_pkg::STAT_CBE_BIT];
	assign start = pend_q && eng_q == fcev_pkg::ENG_IDLE;

	always_comb begin
		div_d = div_q;
		stat_d = stat_q;
		cmd_d = cmd_q;
		margin_d = margin_q;
		seq_d = seq_q;
		sel_d = sel_q;
		pend_d = pend_q;
		if (wr_fire && wstrb0_q) begin
			case (awaddr_q)
				fcev_pkg::OFF_DIV: begin
					div_d.prescale_select = wdata_q[fcev_pkg::DIV_PRESCALE_BIT];
					div_d.divide_field = wdata_q[fcev_pkg::DIV_FIELD_W-1:0];
					div_d.loaded = 1'b1;
				end
				fcev_pkg::OFF_TEST: margin_d = wdata_q[fcev_pkg::TEST_MARGIN_LSB +: fcev_pkg::MARGIN_W];
				fcev_pkg::OFF_ARRAY: begin
					if (stat_q.cbe && seq_q == fcev_pkg::SEQ_IDLE) begin
						seq_d = fcev_pkg::SEQ_ADDR;
						sel_d = wdata_q[NUM_BLOCKS-1:0];
					end else begin
						stat_d.access_error_flag = 1'b1;
					end
				end
				fcev_pkg::OFF_CMD: begin
					if (seq_q == fcev_pkg::SEQ_ADDR && wdata_q[fcev_pkg::CMD_W-1:0] == fcev_pkg::CMD_ERASE_VERIFY) begin
						cmd_d = wdata_q[fcev_pkg::CMD_W-1:0];
						seq_d = fcev_pkg::SEQ_CMD;
					end else begin
						stat_d.access_error_flag = 1'b1;
						seq_d = fcev_pkg::SEQ_IDLE;
					end
				end
				fcev_pkg::OFF_STAT: begin
					// write one clears the error, a new error in the same cycle wins
					if (wdata_q[fcev_pkg::STAT_ACCESS_ERROR_FLAG_BIT]) begin
						stat_d.access_error_flag = 1'b0;
					end
				end
				default: ;
			endcase
		end
		if (launch && seq_q == fcev_pkg::SEQ_CMD) begin
			seq_d = fcev_pkg::SEQ_IDLE;
			if (!div_q.loaded) begin
				stat_d.access_error_flag = 1'b1;
			end else begin
				stat_d.cbe = 1'b0;
				stat_d.cc = 1'b0;
				pend_d = 1'b1;
			end
		end
		if (start) begin
			stat_d.cbe = 1'b1;
			stat_d.blank = 1'b0;
			pend_d = 1'b0;
		end
		if (eng_done || eng_fail) begin
			stat_d.blank = eng_done;
			if (!pend_d) begin
				stat_d.cc = 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			div_q <= '{loaded: 1'b0, prescale_select: 1'b0, divide_field: fcev_pkg::DIV_FIELD_RESET};
			stat_q <= '{cbe: 1'b1, cc: 1'b1, access_error_flag: 1'b0, blank: 1'b0};
			cmd_q <= fcev_pkg::CMD_RESET;
			margin_q <= fcev_pkg::MARGIN_RESET;
			seq_q <= fcev_pkg::SEQ_IDLE;
			sel_q <= '0;
			pend_q <= 1'b0;
		end else begin
			div_q <= div_d;
			stat_q <= stat_d;
			cmd_q <= cmd_d;
			margin_q <= margin_d;
			seq_q <= seq_d;
			sel_q <= sel_d;
			pend_q <= pend_d;
		end
	end

	// erase verify engine
	always_comb begin
		eng_d = eng_q;
		cnt_d = cnt_q;
		run_sel_d = run_sel_q;
		rd_en_d = 1'b0;
		rd_addr_d = rd_addr_q;
		eng_done = 1'b0;
		eng_fail = 1'b0;
		case (eng_q)
			fcev_pkg::ENG_IDLE: begin
				if (start) begin
					eng_d = fcev_pkg::ENG_VERIFY;
					cnt_d = '0;
					run_sel_d = sel_q;
				end
			end
			fcev_pkg::ENG_VERIFY: begin
				cnt_d = cnt_q + 1'b1;
				if (cnt_q >= CNT_SCAN_LO && cnt_q < CNT_SCAN_HI) begin
					rd_en_d = 1'b1;
					rd_addr_d = AW'(cnt_q - CNT_SCAN_LO);
				end
				if (rd_en_q && |(run_sel_q & ~array_blank)) begin
					eng_fail = 1'b1;
					rd_en_d = 1'b0;
					eng_d = fcev_pkg::ENG_IDLE;
				end else if (cnt_q == CNT_DONE) begin
					eng_done = 1'b1;
					eng_d = fcev_pkg::ENG_IDLE;
				end
			end
			default: eng_d = fcev_pkg::ENG_IDLE;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			eng_q <= fcev_pkg::ENG_IDLE;
			cnt_q <= '0;
			run_sel_q <= '0;
			rd_en_q <= 1'b0;
			rd_addr_q <= '0;
		end else begin
			eng_q <= eng_d;
			cnt_q <= cnt_d;
			run_sel_q <= run_sel_d;
			rd_en_q <= rd_en_d;
			rd_addr_q <= rd_addr_d;
		end
	end

	assign array_rd_en = rd_en_q;
	assign array_rd_addr = rd_addr_q;
	assign array_rd_blocks = run_sel_q;
	assign array_margin = margin_q;

	// timing tick for program and erase pacing
	fcev_clk_div u_clk_div (
		.aclk(aclk),
		.aresetn(aresetn),
		.osc_tick(osc_tick),
		.div(div_q),
		.flash_timing_tick(flash_timing_tick)
	);

endmodule : fcev_top

// [fcev_checker.sv]
// checker: bus handshake and erase verify scan properties
// assumes binding onto fcev_top, one bus clock
module fcev_checker #(
	parameter int unsigned BLOCK_ADDRS = 32768,
	parameter int unsigned NUM_BLOCKS = 4
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic array_rd_en,
	input wire logic [$clog2(BLOCK_ADDRS)-1:0] array_rd_addr,
	input wire logic [NUM_BLOCKS-1:0] array_rd_blocks,
	input wire logic [NUM_BLOCKS-1:0] array_blank
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read response dropped early");
	chk_aw_refuse: assert property (s_axi_bvalid |-> !s_axi_awready)
		else $error("write address accepted during response");
	chk_ar_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read address accepted during response");
	chk_b_answer: assert property (s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid)
		else $error("write response missing");
	chk_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read response late");
	chk_scan_start: assert property ($rose(array_rd_en) |-> array_rd_addr == '0)
		else $error("scan does not start at address zero");
	chk_scan_step: assert property (array_rd_en && $past(array_rd_en) |-> array_rd_addr == $past(array_rd_addr) + 1'h1)
		else $error("scan skipped an address");
	chk_scan_mask: assert property (array_rd_en && $past(array_rd_en) |-> $stable(array_rd_blocks))
		else $error("block selection changed in scan");
	chk_early_stop: assert property (array_rd_en && |(array_rd_blocks & ~array_blank) |=> !array_rd_en)
		else $error("scan continued past dirty word");
	cov_write: cover property (s_axi_bvalid && s_axi_bready);
	cov_read: cover property (s_axi_rvalid && s_axi_rready);
	cov_scan_end: cover property ($fell(array_rd_en));
endmodule : fcev_checker

bind fcev_top fcev_checker #(.BLOCK_ADDRS(BLOCK_ADDRS), .NUM_BLOCKS(NUM_BLOCKS)) u_fcev_checker (
	.aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.array_rd_en(array_rd_en), .array_rd_addr(array_rd_addr), .array_rd_blocks(array_rd_blocks),
	.array_blank(array_blank));

// [tb_flash_clock_and_erase_verify.sv]
// testbench: divider setup and erase verify over axi4-lite
// assumes fcev_top with 16 addresses a block, osc_tick every other cycle
module tb_flash_clock_and_erase_verify;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [31:0] CBE = 32'h1 << fcev_pkg::STAT_CBE_BIT;
	localparam logic [31:0] CC = 32'h1 << fcev_pkg::STAT_CC_BIT;
	localparam logic [31:0] AE = 32'h1 << fcev_pkg::STAT_ACCESS_ERROR_FLAG_BIT;
	localparam logic [31:0] BL = 32'h1 << fcev_pkg::STAT_BLANK_BIT;
	localparam logic [2:0] OK = {1'h1, fcev_pkg::RESP_OKAY};
	logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, dirty;
	logic arvalid, arready, rvalid, rready, osc_tick, tick, rd_en;
	logic [4:0] awaddr, araddr;
	logic [31:0] wdata, rdata, last_r, d, seed;
	logic [1:0] bresp, rresp, margin;
	logic [3:0] rd_addr, blocks, blank, exp_blk;
	logic [34:0] rq[$];
	logic [2:0] bq[$];
	logic [34:0] rn;
	logic [2:0] bn;
	int bad_count, n_checks, rd_cyc, k;
	fcev_top #(.BLOCK_ADDRS(16), .NUM_BLOCKS(4)) DUT (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.osc_tick(osc_tick), .flash_timing_tick(tick), .array_rd_en(rd_en), .array_rd_addr(rd_addr),
		.array_rd_blocks(blocks), .array_margin(margin), .array_blank(blank));
	initial begin
		aclk = 1'h0;
		forever #50 aclk = ~aclk;
	end
	// same-cycle array answer, one dirty word when asked
	assign blank = (dirty && rd_addr == 4'h5) ? 4'hE : 4'hF;
	always @(posedge aclk) osc_tick <= ~osc_tick;
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		s = s ^ (s << 5);
		return s;
	endfunction : xs
	task automatic cmp_data(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : cmp_data
	task automatic cmp_resp(input string nm, input logic [1:0] e, input logic [1:0] g);
		n_checks++;
		if (g !== e) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : cmp_resp
	// results seen the half cycle before the handshake edge
	always @(negedge aclk) begin
		if (bvalid && bready) begin
			bn = bq.pop_front();
			if (bn[2]) cmp_resp("bresp", bn[1:0], bresp);
		end
		if (rvalid && rready) begin
			rn = rq.pop_front();
			last_r = rdata;
			if (rn[32]) cmp_data("rdata", rn[31:0], rdata);
			cmp_resp("rresp", rn[34:33], rresp);
		end
		if (rd_en) begin
			rd_cyc++;
			cmp_data("blocks", 32'(exp_blk), 32'(blocks));
			cmp_resp("margin", 2'h3, margin);
		end
	end
	task automatic wr(input logic [4:0] a, input logic [31:0] v, input logic [2:0] e);
		int n;
		logic ta, tw, tb;
		bq.push_back(e);
		@(posedge aclk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		tb = 1'h0;
		for (n = 0; n < 100 && !tb; n++) begin
			@(negedge aclk);
			ta = awvalid && awready;
			tw = wvalid && wready;
			tb = bvalid;
			@(posedge aclk);
			if (ta) awvalid <= 1'h0;
			if (tw) wvalid <= 1'h0;
			if (tb) bready <= 1'h0;
		end
		if (!tb) begin
			bad_count++;
			wrap_up();
		end
	endtask : wr
	task automatic rd(input logic [4:0] a, input logic c, input logic [31:0] e);
		int n;
		logic ta, tr;
		rq.push_back({(a > fcev_pkg::OFF_ARRAY) ? fcev_pkg::RESP_SLVERR : fcev_pkg::RESP_OKAY, c, e});
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		tr = 1'h0;
		for (n = 0; n < 100 && !tr; n++) begin
			@(negedge aclk);
			ta = arvalid && arready;
			tr = rvalid;
			@(posedge aclk);
			if (ta) arvalid <= 1'h0;
			if (tr) rready <= 1'h0;
		end
		if (!tr) begin
			bad_count++;
			wrap_up();
		end
	endtask : rd
	task automatic ev(input logic [3:0] m);
		exp_blk = m;
		wr(5'h10, 32'(m), 3'h0);
		wr(fcev_pkg::OFF_CMD, 32'(fcev_pkg::CMD_ERASE_VERIFY), 3'h0);
		wr(fcev_pkg::OFF_STAT, CBE, 3'h0);
	endtask : ev
	task automatic poll();
		int n;
		last_r = 32'h0;
		for (n = 0; n < 100 && last_r[fcev_pkg::STAT_CC_BIT] !== 1'h1; n++) rd(fcev_pkg::OFF_STAT, 1'h0, 32'h0);
		if (last_r[fcev_pkg::STAT_CC_BIT] !== 1'h1) begin
			bad_count++;
			wrap_up();
		end
	endtask : poll
	task automatic per(input int e);
		int n, c;
		c = 0;
		for (n = 0; n < 400 && tick !== 1'h1; n++) @(negedge aclk);
		if (tick !== 1'h1) begin
			bad_count++;
			wrap_up();
		end
		for (n = 0; n < 400 && (c == 0 || tick !== 1'h1); n++) begin
			@(negedge aclk);
			c++;
		end
		cmp_data("tick period", e, c);
	endtask : per
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : wrap_up
	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, osc_tick, dirty} = 8'h0;
		{awaddr, araddr, wdata, exp_blk} = '0;
		seed = 32'h28CEB7FB;
		{bad_count, n_checks, rd_cyc} = '0;
		repeat (6) @(posedge aclk);
		aresetn <= 1'h1;
		rd(fcev_pkg::OFF_DIV, 1'h1, 32'h0);
		rd(fcev_pkg::OFF_STAT, 1'h1, CBE | CC);
		ev(4'h1);
		rd(fcev_pkg::OFF_STAT, 1'h1, CBE | CC | AE);
		wr(fcev_pkg::OFF_STAT, AE, OK);
		rd(fcev_pkg::OFF_STAT, 1'h1, CBE | CC);
		for (k = 0; k < 2; k++) begin
			seed = xs(seed);
			d = k ? 32'h43 : 32'h18 + 32'(seed[2:0]);
			wr(fcev_pkg::OFF_DIV, d, OK);
			rd(fcev_pkg::OFF_DIV, 1'h1, d | 32'h80);
			repeat (40) @(negedge aclk);
			per(2 * (d[5:0] + 1) * (k ? 8 : 1));
		end
		wr(fcev_pkg::OFF_TEST, 32'h30, OK);
		rd(fcev_pkg::OFF_TEST, 1'h1, 32'h30);
		rd_cyc = 0;
		ev(4'h5);
		rd(fcev_pkg::OFF_STAT, 1'h1, CBE);
		poll();
		cmp_data("scan cycles", 32'h10, rd_cyc);
		rd(fcev_pkg::OFF_STAT, 1'h1, CBE | CC | BL);
		dirty <= 1'h1;
		rd_cyc = 0;
		ev(4'h1);
		poll();
		cmp_data("scan cycles", 32'h6, rd_cyc);
		rd(fcev_pkg::OFF_STAT, 1'h1, CBE | CC);
		dirty <= 1'h0;
		rd_cyc = 0;
		ev(4'h3);
		ev(4'h3);
		poll();
		cmp_data("scan cycles", 32'h20, rd_cyc);
		wr(5'h14, 32'h0, {1'h1, fcev_pkg::RESP_SLVERR});
		rd(5'h14, 1'h1, 32'h0);
		wrap_up();
	end
endmodule : tb_flash_clock_and_erase_verify
